// ---- common/occi_regs.svh ----
// Register indices, field positions, codes and reset values for the output compare interrupt block
`ifndef OCCI_REGS_SVH
`define OCCI_REGS_SVH

// Register indices; byte address is four times the index
`define OCCI_IDX_CH1_SEC 16'h0180
`define OCCI_IDX_CH1_MAIN 16'h0182
`define OCCI_IDX_CH1_CTRL 16'h0184
`define OCCI_IDX_CH2_SEC 16'h0186
`define OCCI_IDX_CH2_MAIN 16'h0188
`define OCCI_IDX_CH2_CTRL 16'h018a
`define OCCI_IDX_CH3_SEC 16'h018c
`define OCCI_IDX_CH3_MAIN 16'h018e
`define OCCI_IDX_CH3_CTRL 16'h0110
`define OCCI_IDX_CH4_SEC 16'h0192
`define OCCI_IDX_CH4_MAIN 16'h0194
`define OCCI_IDX_CH4_CTRL 16'h9610
`define OCCI_IDX_IRQ_STAT 16'h01a0
`define OCCI_IDX_IRQ_MASK 16'h01a2

// Control register fields
`define OCCI_CTRL_MODE_LSB 0
`define OCCI_CTRL_MODE_MSB 2
`define OCCI_CTRL_TSEL_BIT 3
`define OCCI_CTRL_FLT_BIT 4
`define OCCI_CTRL_IDLE_BIT 13

// Mode codes
`define OCCI_MODE_OFF 3'h0
`define OCCI_MODE_LOW 3'h1
`define OCCI_MODE_HIGH 3'h2
`define OCCI_MODE_TOGGLE 3'h3
`define OCCI_MODE_SINGLE 3'h4
`define OCCI_MODE_CONT 3'h5
`define OCCI_MODE_PWM 3'h6
`define OCCI_MODE_PWM_FLT 3'h7

// Interrupt status and mask layout: bits 3:0 channel flags, then timer A, timer B
`define OCCI_STAT_W 6
`define OCCI_STAT_CH_MSB 3
`define OCCI_STAT_TA_BIT 4
`define OCCI_STAT_TB_BIT 5

// Reset values
`define OCCI_REG_RESET 16'h0000
`define OCCI_STAT_RESET 6'h00
`define OCCI_RDATA_RESET 32'h0000_0000

`endif

// ---- common/occi_pkg.sv ----
// Types shared by the output compare interrupt block
`include "occi_regs.svh"
package occi_pkg;
    // Channel operating mode
    typedef enum logic [2:0] {
        OCCI_OFF = `OCCI_MODE_OFF,
        OCCI_LOW = `OCCI_MODE_LOW,
        OCCI_HIGH = `OCCI_MODE_HIGH,
        OCCI_TOGGLE = `OCCI_MODE_TOGGLE,
        OCCI_SINGLE = `OCCI_MODE_SINGLE,
        OCCI_CONT = `OCCI_MODE_CONT,
        OCCI_PWM = `OCCI_MODE_PWM,
        OCCI_PWM_FLT = `OCCI_MODE_PWM_FLT
    } occi_mode_e;
    // One 16-bit register word
    typedef logic [15:0] occi_word_t;
endpackage

// ---- common/occi_ch_if.sv ----
// Interface between the register core and one compare channel
`timescale 1ns/100ps
interface occi_ch_if;
    import occi_pkg::*;
    occi_mode_e mode;     // Current channel mode
    logic run;            // Low while the channel is halted in idle
    occi_word_t main_val; // Active compare / duty value
    occi_word_t sec_val;  // Secondary compare / next duty
    occi_word_t count;    // Selected timer count
    occi_word_t period;   // Selected timer period
    logic tick;           // Selected timer increment pulse
    logic fault_n;        // Fault input, low means fault
    logic fault_q;        // Latched fault status
    logic cmp_evt;        // Compare event, match modes only
    logic pwm_evt;        // Period event, PWM modes only
    logic fault_det;      // Fault seen in fault-protected PWM
    logic pin;            // Pin level
    logic pin_oe;         // Pin drive enable
    modport ctl (output mode, run, main_val, sec_val, count, period, tick, fault_n, fault_q,
                 input cmp_evt, pwm_evt, fault_det, pin, pin_oe);
    modport ch (input mode, run, main_val, sec_val, count, period, tick, fault_n, fault_q,
                output cmp_evt, pwm_evt, fault_det, pin, pin_oe);
endinterface

// ---- core/occi_channel.sv ----
// One compare channel: event detection and pin drive
`timescale 1ns/100ps
module occi_channel
    import occi_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    occi_ch_if.ch chi
);
    // Mode classes
    wire is_pwm = (chi.mode == OCCI_PWM) || (chi.mode == OCCI_PWM_FLT);
    wire is_dual = (chi.mode == OCCI_SINGLE) || (chi.mode == OCCI_CONT);
    wire is_match = (chi.mode != OCCI_OFF) && !is_pwm;
    // Comparisons gated by the increment pulse so each count value matches once
    wire hit_main = chi.run && chi.tick && (chi.count == chi.main_val);
    wire hit_sec = chi.run && chi.tick && (chi.count == chi.sec_val);
    wire hit_per = chi.run && chi.tick && (chi.count == chi.period);
    wire duty_over = chi.main_val > chi.period;
    logic pin_q, pin_d, oe_q;

    // Channel flag source never fires in PWM modes
    assign chi.cmp_evt = is_match && (hit_main || (is_dual && hit_sec));
    // Period event is taken on the same increment as the period match
    assign chi.pwm_evt = is_pwm && hit_per;
    assign chi.fault_det = (chi.mode == OCCI_PWM_FLT) && !chi.fault_n;
    assign chi.pin = pin_q;
    assign chi.pin_oe = oe_q;

    // Next pin level per mode
    always_comb begin
        pin_d = pin_q;
        case (chi.mode)
            OCCI_OFF: pin_d = 1'b0;
            OCCI_LOW: if (hit_main) pin_d = 1'b0;
            OCCI_HIGH: if (hit_main) pin_d = 1'b1;
            OCCI_TOGGLE: if (hit_main) pin_d = !pin_q;
            OCCI_SINGLE, OCCI_CONT: begin
                // Rising edge on main, falling edge on secondary
                if (hit_main) pin_d = 1'b1;
                else if (hit_sec) pin_d = 1'b0;
            end
            OCCI_PWM, OCCI_PWM_FLT: begin
                // Zero duty stays low; duty above period never clears the pin
                if (hit_per) pin_d = (chi.sec_val != `OCCI_REG_RESET);
                else if (hit_main && !duty_over) pin_d = 1'b0;
            end
            default: pin_d = 1'b0;
        endcase
    end

    // Pin and enable flops; a fault floats the pin until cleared
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            oe_q <= (chi.mode != OCCI_OFF) && !chi.fault_q && !chi.fault_det;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_cmp_on_match;
        chi.cmp_evt |-> (chi.count == chi.main_val) || (chi.count == chi.sec_val);
    endproperty
    a_cmp_on_match: assert property (p_cmp_on_match) else $error("compare event without match");

    property p_pwm_mode_only;
        chi.pwm_evt |-> (chi.mode == OCCI_PWM || chi.mode == OCCI_PWM_FLT) && !chi.cmp_evt;
    endproperty
    a_pwm_mode_only: assert property (p_pwm_mode_only) else $error("period event outside PWM");
endmodule

// ---- core/occi_top.sv ----
// Output compare interrupt block: APB registers, four channels, interrupt flags
`timescale 1ns/100ps
`include "occi_regs.svh"
module occi_top
    import occi_pkg::*;
#(
    parameter int NCH = 4
)(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timer_a_count,
    input wire logic [15:0] timer_a_period,
    input wire logic timer_a_tick,
    input wire logic [15:0] timer_b_count,
    input wire logic [15:0] timer_b_period,
    input wire logic timer_b_tick,
    input wire logic cpu_idle,
    input wire logic fault_in_n,
    output logic [3:0] oc_pin,
    output logic [3:0] oc_pin_oe,
    output logic irq
);
    // Register index tables, one entry per channel
    localparam logic [15:0] IDX_SEC [4] = '{`OCCI_IDX_CH1_SEC, `OCCI_IDX_CH2_SEC,
                                            `OCCI_IDX_CH3_SEC, `OCCI_IDX_CH4_SEC};
    localparam logic [15:0] IDX_MAIN [4] = '{`OCCI_IDX_CH1_MAIN, `OCCI_IDX_CH2_MAIN,
                                             `OCCI_IDX_CH3_MAIN, `OCCI_IDX_CH4_MAIN};
    localparam logic [15:0] IDX_CTRL [4] = '{`OCCI_IDX_CH1_CTRL, `OCCI_IDX_CH2_CTRL,
                                             `OCCI_IDX_CH3_CTRL, `OCCI_IDX_CH4_CTRL};

    // Bus decode
    wire [15:0] idx = paddr[17:2];          // Word index of the access
    wire setup = psel && !penable;          // APB setup phase
    logic pready_q, pslverr_q;              // Registered answer flags
    logic [31:0] prdata_q;                  // Registered read data
    wire wr_en = psel && penable && pwrite && pready_q && !pslverr_q;
    wire hit_stat = (idx == `OCCI_IDX_IRQ_STAT);
    wire hit_mask = (idx == `OCCI_IDX_IRQ_MASK);

    // Per-channel gathered signals
    logic [NCH-1:0] hit_sec, hit_main, hit_ctrl;
    logic [NCH-1:0] cmp_evt_v, pwm_evt_v, tsel_v, is_pwm_v;
    logic [NCH-1:0][15:0] sec_v, main_v, ctrl_v;
    logic [3:0] pin_v, oe_v;

    // Interrupt status and mask
    logic [`OCCI_STAT_W-1:0] stat_q, stat_d, mask_q, mask_d, ev_set, clr_w, keep_w;
    logic irq_q;

    // Any mapped index; every other index is refused with an error
    wire hit_any = (|hit_sec) || (|hit_main) || (|hit_ctrl) || hit_stat || hit_mask;
    wire wr_stat = wr_en && hit_stat;
    wire wr_mask = wr_en && hit_mask;

    // One register set and one channel per compare output
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            occi_ch_if chi();
            occi_word_t sec_q, main_q;     // Compare registers
            occi_mode_e mode_q;            // Mode field
            logic tsel_q, sidl_q, flt_q;   // Timer select, idle halt, fault status
            logic [15:0] ctrl_rd;          // Control readback word
            wire pwm_now = (mode_q == OCCI_PWM) || (mode_q == OCCI_PWM_FLT);

            // Index decode for this channel's three registers
            assign hit_sec[i] = (idx == IDX_SEC[i]);
            assign hit_main[i] = (idx == IDX_MAIN[i]);
            assign hit_ctrl[i] = (idx == IDX_CTRL[i]);

            // Time base chosen by the select bit, timer A by default
            assign chi.count = tsel_q ? timer_b_count : timer_a_count;
            assign chi.period = tsel_q ? timer_b_period : timer_a_period;
            assign chi.tick = tsel_q ? timer_b_tick : timer_a_tick;
            assign chi.mode = mode_q;
            assign chi.run = !(sidl_q && cpu_idle);
            assign chi.main_val = main_q;
            assign chi.sec_val = sec_q;
            assign chi.fault_n = fault_in_n;
            assign chi.fault_q = flt_q;

            assign cmp_evt_v[i] = chi.cmp_evt;
            assign pwm_evt_v[i] = chi.pwm_evt;
            assign tsel_v[i] = tsel_q;
            assign is_pwm_v[i] = pwm_now;
            assign sec_v[i] = sec_q;
            assign main_v[i] = main_q;
            assign ctrl_v[i] = ctrl_rd;
            assign pin_v[i] = chi.pin;
            assign oe_v[i] = chi.pin_oe;

            // Control readback; unused bits read as zero
            always_comb begin
                ctrl_rd = `OCCI_REG_RESET;
                ctrl_rd[`OCCI_CTRL_MODE_MSB:`OCCI_CTRL_MODE_LSB] = mode_q;
                ctrl_rd[`OCCI_CTRL_TSEL_BIT] = tsel_q;
                ctrl_rd[`OCCI_CTRL_FLT_BIT] = flt_q;
                ctrl_rd[`OCCI_CTRL_IDLE_BIT] = sidl_q;
            end

            // Secondary register, software owned
            always_ff @(posedge core_clk) begin
                if (sys_rst) sec_q <= `OCCI_REG_RESET;
                else if (wr_en && hit_sec[i]) sec_q <= pwdata[15:0];
            end

            // Main register; read-only while in PWM, reloaded on each period event
            always_ff @(posedge core_clk) begin
                if (sys_rst) main_q <= `OCCI_REG_RESET;
                else if (chi.pwm_evt) main_q <= sec_q;
                else if (wr_en && hit_main[i] && !pwm_now) main_q <= pwdata[15:0];
            end

            // Control fields
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    mode_q <= OCCI_OFF;
                    tsel_q <= 1'b0;
                    sidl_q <= 1'b0;
                end else if (wr_en && hit_ctrl[i]) begin
                    mode_q <= occi_mode_e'(pwdata[`OCCI_CTRL_MODE_MSB:`OCCI_CTRL_MODE_LSB]);
                    tsel_q <= pwdata[`OCCI_CTRL_TSEL_BIT];
                    sidl_q <= pwdata[`OCCI_CTRL_IDLE_BIT];
                end
            end

            // Fault status holds until the fault is gone and the control is rewritten
            // Fault set has priority so a write during a live fault cannot clear it
            always_ff @(posedge core_clk) begin
                if (sys_rst) flt_q <= 1'b0;
                else if (chi.fault_det) flt_q <= 1'b1;
                else if (wr_en && hit_ctrl[i]) flt_q <= 1'b0;
            end

            // Event detection and pin drive live in the channel module
            occi_channel u_ch (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .chi(chi.ch)
            );
        end
    endgenerate

    // Event sources: channel flags in match modes, timer flags in PWM
    assign ev_set[`OCCI_STAT_CH_MSB:0] = cmp_evt_v;
    assign ev_set[`OCCI_STAT_TA_BIT] = |(pwm_evt_v & ~tsel_v);
    assign ev_set[`OCCI_STAT_TB_BIT] = |(pwm_evt_v & tsel_v);
    // Write-one-to-clear; a coincident event wins over the clear
    assign clr_w = wr_stat ? pwdata[`OCCI_STAT_W-1:0] : `OCCI_STAT_RESET;
    assign keep_w = stat_q & ~clr_w;
    assign stat_d = keep_w | ev_set;
    assign mask_d = wr_mask ? pwdata[`OCCI_STAT_W-1:0] : mask_q;

    // Read selection
    logic [15:0] rd_word;
    always_comb begin
        rd_word = `OCCI_REG_RESET;
        for (int k = 0; k < NCH; k++) begin
            if (hit_sec[k]) rd_word = sec_v[k];
            if (hit_main[k]) rd_word = main_v[k];
            if (hit_ctrl[k]) rd_word = ctrl_v[k];
        end
        if (hit_stat) rd_word = {10'h000, stat_q};
        if (hit_mask) rd_word = {10'h000, mask_q};
    end

    // Flags and mask; interrupt is computed from next values so it never lags a mask clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stat_q <= `OCCI_STAT_RESET;
            mask_q <= `OCCI_STAT_RESET;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
        end
    end

    // APB answer: always ready in the first access cycle, error on unmapped index
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `OCCI_RDATA_RESET;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q <= (setup && !pwrite && hit_any) ? {16'h0000, rd_word} : `OCCI_RDATA_RESET;
        end
    end

    // Outputs come straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign oc_pin = pin_v;
    assign oc_pin_oe = oe_v;
    assign irq = irq_q;

    // Checks below share one clock and are quiet while reset is held
    // They watch internal state, so they catch faults that bus reads would hide
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_cmp_sets_flag;
        (|cmp_evt_v) |=> ((stat_q[`OCCI_STAT_CH_MSB:0] & $past(cmp_evt_v)) == $past(cmp_evt_v));
    endproperty
    a_cmp_sets_flag: assert property (p_cmp_sets_flag) else $error("compare flag not set");

    property p_flag_sticky;
        ##1 ((stat_q & $past(keep_w)) == $past(keep_w));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write");

    property p_irq_gate;
        irq_q == (|(stat_q & mask_q));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt disagrees with flags");

    property p_pwm_timer_a;
        (|(pwm_evt_v & ~tsel_v)) |=> stat_q[`OCCI_STAT_TA_BIT];
    endproperty
    a_pwm_timer_a: assert property (p_pwm_timer_a) else $error("timer A flag not set");

    property p_pwm_timer_b;
        (|(pwm_evt_v & tsel_v)) |=> stat_q[`OCCI_STAT_TB_BIT];
    endproperty
    a_pwm_timer_b: assert property (p_pwm_timer_b) else $error("timer B flag not set");

    property p_timer_irq;
        (stat_q[`OCCI_STAT_TA_BIT] && !mask_q[`OCCI_STAT_TA_BIT] && !(|(stat_q & mask_q))) |-> !irq_q;
    endproperty
    a_timer_irq: assert property (p_timer_irq) else $error("timer flag interrupt not gated");

    property p_pwm_no_cmp;
        ((stat_q[`OCCI_STAT_CH_MSB:0] & is_pwm_v) == 4'h0) |=>
            ((stat_q[`OCCI_STAT_CH_MSB:0] & $past(is_pwm_v)) == 4'h0);
    endproperty
    a_pwm_no_cmp: assert property (p_pwm_no_cmp) else $error("channel flag set in PWM");

    property p_reset_sec;
        $past(sys_rst) |-> (sec_v == '0);
    endproperty
    a_reset_sec: assert property (p_reset_sec) else $error("secondary not cleared by reset");

    property p_reset_main;
        $past(sys_rst) |-> (main_v == '0);
    endproperty
    a_reset_main: assert property (p_reset_main) else $error("main not cleared by reset");

    property p_duty_latch;
        pwm_evt_v[1] |=> (main_v[1] == $past(sec_v[1]));
    endproperty
    a_duty_latch: assert property (p_duty_latch) else $error("duty not latched");

    property p_set_wins;
        (cmp_evt_v[0] && wr_stat && pwdata[0]) |=> stat_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat event");

    // Bus answer lasts exactly one cycle and errors only ride with it
    property p_ready_pulse;
        pready_q |=> !pready_q;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past one cycle");

    property p_err_with_ready;
        pslverr_q |-> pready_q;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

    // Read data is zero outside the answer cycle so stale values never leak
    property p_rdata_idle;
        !pready_q |-> (prdata_q == `OCCI_RDATA_RESET);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

    // A flag rises only from an event, never from a bus write
    property p_flag_source;
        ##1 ((stat_q & ~$past(stat_q) & ~$past(ev_set)) == `OCCI_STAT_RESET);
    endproperty
    a_flag_source: assert property (p_flag_source) else $error("flag set without event");

    // A mask write lands at the edge that ends its access cycle
    property p_mask_write;
        wr_mask |=> (mask_q == $past(pwdata[`OCCI_STAT_W-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    // Scenarios the bench reaches, all but c_cmp_flag, which needs a mask bit set while ch1 is in a match mode
    c_cmp_flag: cover property (cmp_evt_v[0] ##1 irq_q);
    c_pwm_evt: cover property (pwm_evt_v[1] ##1 stat_q[`OCCI_STAT_TA_BIT]);
    c_clear: cover property (stat_q[0] ##1 wr_stat ##1 !stat_q[0]);
    c_slverr: cover property (pslverr_q && pready_q);
endmodule

// ---- tb/occi_timer_model.sv ----
// Behavioural model of the two shared timer bases feeding the compare block
`timescale 1ns/100ps
module occi_timer_model #(
    parameter int PER_A = 9, // Timer A period, plain default
    parameter int PER_B = 7  // Timer B period, plain default
)(
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic [15:0] count_a,
    output logic [15:0] period_a,
    output logic tick_a,
    output logic [15:0] count_b,
    output logic [15:0] period_b,
    output logic tick_b
);
    logic div_q; // Increments on every other cycle so the block sees slow timers

    // Periods stay constant for the whole run
    assign period_a = PER_A[15:0];
    assign period_b = PER_B[15:0];

    // Counts wrap to zero on the increment after a period match
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= 1'b0;
            tick_a <= 1'b0;
            tick_b <= 1'b0;
            count_a <= 16'h0000;
            count_b <= 16'h0000;
        end else begin
            div_q <= ~div_q;
            tick_a <= div_q;
            tick_b <= div_q;
            // Count moves at the edge where tick is high, so compares see the old count
            if (tick_a) begin
                count_a <= (count_a == period_a) ? 16'h0000 : count_a + 16'h0001;
            end
            if (tick_b) begin
                count_b <= (count_b == period_b) ? 16'h0000 : count_b + 16'h0001;
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the output compare interrupt block
`timescale 1ns/100ps
`include "occi_regs.svh"
module testbench;
    import occi_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] ta_count, ta_period, tb_count, tb_period;
    logic ta_tick, tb_tick;
    logic [3:0] oc_pin, oc_pin_oe;
    logic irq;
    int errors = 0;
    int comparisons = 0;
    // Register index tables per channel, ch1 first
    logic [15:0] sec_idx [4] = '{`OCCI_IDX_CH1_SEC, `OCCI_IDX_CH2_SEC, `OCCI_IDX_CH3_SEC, `OCCI_IDX_CH4_SEC};
    logic [15:0] main_idx [4] = '{`OCCI_IDX_CH1_MAIN, `OCCI_IDX_CH2_MAIN, `OCCI_IDX_CH3_MAIN, `OCCI_IDX_CH4_MAIN};
    logic [15:0] ctrl_idx [4] = '{`OCCI_IDX_CH1_CTRL, `OCCI_IDX_CH2_CTRL, `OCCI_IDX_CH3_CTRL, `OCCI_IDX_CH4_CTRL};

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    occi_top #(.NCH(4)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_a_count(ta_count), .timer_a_period(ta_period), .timer_a_tick(ta_tick),
        .timer_b_count(tb_count), .timer_b_period(tb_period), .timer_b_tick(tb_tick),
        .cpu_idle(1'b0), .fault_in_n(1'b1), .oc_pin(oc_pin), .oc_pin_oe(oc_pin_oe), .irq(irq));

    occi_timer_model timers (.core_clk(core_clk), .sys_rst(sys_rst), .count_a(ta_count), .period_a(ta_period),
        .tick_a(ta_tick), .count_b(tb_count), .period_b(tb_period), .tick_b(tb_tick));

    // One compare; four-state equality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a dead slave
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic e;
        apb(1'b1, idx, wd, rd, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, idx, 32'h0, rd, e);
        chk(rd, exp);
    endtask

    // Poll status until one bit is set; a bounded poll so a missing event fails
    task automatic wait_flag(input int b);
        logic [31:0] rd;
        logic e;
        int n;
        n = 0;
        do begin
            apb(1'b0, `OCCI_IDX_IRQ_STAT, 32'h0, rd, e);
            n++;
        end while (rd[b] !== 1'b1 && n < 40);
        chk({31'h0, rd[b]}, 32'h1);
    endtask

    // Every register reads zero after reset; unmapped index is refused
    task automatic t_reset();
        logic [31:0] rd;
        logic e;
        for (int c = 0; c < 4; c++) begin
            rd_chk(sec_idx[c], 32'h0);
            rd_chk(main_idx[c], 32'h0);
            rd_chk(ctrl_idx[c], 32'h0);
        end
        rd_chk(`OCCI_IDX_IRQ_STAT, 32'h0);
        rd_chk(`OCCI_IDX_IRQ_MASK, 32'h0);
        chk({24'h0, oc_pin, oc_pin_oe}, 32'h0);
        apb(1'b1, 16'h0001, 32'h0000_ffff, rd, e);
        chk({31'h0, e}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("Test reset done");
    endtask

    // Every match mode, rotating channel and time base: flag sticks, irq gated by mask
    task automatic t_match();
        int c;
        for (int m = 1; m <= 5; m++) begin
            c = (m - 1) % 4;
            wr(sec_idx[c], 32'h6);
            wr(main_idx[c], 32'h4);
            wr(ctrl_idx[c], {28'h0, m[0], m[2:0]});
            wait_flag(c);
            chk({31'h0, irq}, 32'h0);
            chk({28'h0, oc_pin_oe}, 32'h1 << c);
            if (m <= 2) chk({31'h0, oc_pin[c]}, m - 1);
            wr(ctrl_idx[c], 32'h0);
            repeat (30) @(posedge core_clk);
            chk({24'h0, oc_pin, oc_pin_oe}, 32'h0);
            rd_chk(`OCCI_IDX_IRQ_STAT, 32'h1 << c);
            wr(`OCCI_IDX_IRQ_MASK, 32'h1 << c);
            chk({31'h0, irq}, 32'h1);
            wr(`OCCI_IDX_IRQ_STAT, 32'h1 << c);
            rd_chk(`OCCI_IDX_IRQ_STAT, 32'h0);
            chk({31'h0, irq}, 32'h0);
            wr(`OCCI_IDX_IRQ_MASK, 32'h0);
        end
        $display("Test match modes done");
    endtask

    // Both PWM codes on both time bases: timer flag set, channel flag never, duty latched
    task automatic t_pwm();
        int tb;
        for (int k = 0; k < 4; k++) begin
            tb = k % 2;
            wr(sec_idx[1], 32'h3 + k);
            wr(ctrl_idx[1], {28'h0, tb[0], 2'b11, k[1]});
            wait_flag(`OCCI_STAT_TA_BIT + tb);
            chk({28'h0, oc_pin_oe}, 32'h2);
            rd_chk(main_idx[1], 32'h3 + k);
            wr(main_idx[1], 32'h9);
            rd_chk(main_idx[1], 32'h3 + k);
            rd_chk(`OCCI_IDX_IRQ_STAT, 32'h10 << tb);
            chk({31'h0, irq}, 32'h0);
            wr(`OCCI_IDX_IRQ_MASK, 32'h10 << tb);
            chk({31'h0, irq}, 32'h1);
            wr(ctrl_idx[1], 32'h0);
            wr(`OCCI_IDX_IRQ_STAT, 32'h3f);
            wr(`OCCI_IDX_IRQ_MASK, 32'h0);
            rd_chk(`OCCI_IDX_IRQ_STAT, 32'h0);
        end
        $display("Test pwm modes done");
    endtask

    // Single place where the run ends
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_match();
        t_pwm();
        give_verdict();
    end

    // Watchdog well beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        give_verdict();
    end
endmodule
